// ==== hw/hirq_top.v ====
`timescale 1ns/1ns
`include "hirq_consts.vh"

module hirq_top #(
    parameter AW = 8,
    parameter GPIO_W = 32
) (
    input wire core_clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [GPIO_W-1:0] port_gpio_status,
    input wire vsync_status,
    input wire wait_tmo_evt,
    input wire host_rd_busy,
    input wire host_wr_busy,
    output reg host_irq_pin_o,
    output reg host_irq_pin_oe_n,
    output reg irq
);
    localparam [15:0] ZERO16 = 16'h0000;

    // Write channel holding
    reg aw_hold_q;
    reg [AW-1:0] aw_addr_q;
    reg w_hold_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Registers
    reg [7:0] tmo_ctrl_q;
    reg [1:0] be_en_q;
    reg [2:0] pin_ctl_q;
    reg [`HIRQ_EVT_W-1:0] evt_en_q;

    wire [`HIRQ_EVT_W-1:0] evt_q;
    wire [1:0] bus_err_q;
    wire host_flag_q;
    wire rd_tmo;
    wire wr_tmo;

    wire aw_fire;
    wire w_fire;
    wire do_write;
    wire [7:0] wr_idx;
    wire [7:0] rd_idx;
    wire [15:0] wmask;
    wire [15:0] wval;
    wire wr_hit;
    wire gpio_flag;
    wire [15:0] summary;
    wire req_active;

    reg [1:0] be_clr;
    reg [1:0] be_set;
    reg host_clr;
    reg [`HIRQ_EVT_W-1:0] evt_clr;
    reg [`HIRQ_EVT_W-1:0] evt_set;
    reg [31:0] rd_mux;
    reg rd_ok;

    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    // Write commits once both halves are held and no response stands
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    // Word index, padded back to the width of the map constants
    assign wr_idx = {2'b00, aw_addr_q[AW-1:2]};
    assign rd_idx = {2'b00, s_axi_araddr[AW-1:2]};
    assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wval = w_data_q[15:0];

    // Mapped words answer OKAY even where the write has no effect
    assign wr_hit = (wr_idx == `HIRQ_IDX_SUMMARY) ||
        (wr_idx == `HIRQ_IDX_TMO_CTRL) ||
        (wr_idx == `HIRQ_IDX_BUS_ERR) ||
        (wr_idx == `HIRQ_IDX_BE_EN) ||
        (wr_idx == `HIRQ_IDX_PIN_CTRL) ||
        (wr_idx == `HIRQ_IDX_EVT_STATUS) ||
        (wr_idx == `HIRQ_IDX_EVT_CLEAR) ||
        (wr_idx == `HIRQ_IDX_EVT_ENABLE);

    // GPIO and vsync summary flags are live views of their sources; the host flag is sticky
    assign gpio_flag = |port_gpio_status;

    // Reserved summary bits always read as zero
    function [15:0] hirq_summary;
        input gpio;
        input vsync;
        input host;
        reg [15:0] v;
        begin
            v = ZERO16;
            v[`HIRQ_SUM_GPIO] = gpio;
            v[`HIRQ_SUM_VSYNC] = vsync;
            v[`HIRQ_SUM_HOST] = host;
            hirq_summary = v;
        end
    endfunction

    assign summary = hirq_summary(gpio_flag, vsync_status, host_flag_q);
    assign req_active = pin_ctl_q[2] && (summary != ZERO16);

    // Access supervision, read and write watched alike
    // Counters restart with every access, so one slow access flags once
    hirq_timeout #(
        .W(7)
    ) u_rd_tmo (
        .core_clk(core_clk),
        .rst(rst),
        .busy(host_rd_busy),
        .enable(tmo_ctrl_q[`HIRQ_TMO_EN]),
        .limit(tmo_ctrl_q[`HIRQ_TMO_VAL_HI:0]),
        .tmo_q(rd_tmo)
    );

    hirq_timeout #(
        .W(7)
    ) u_wr_tmo (
        .core_clk(core_clk),
        .rst(rst),
        .busy(host_wr_busy),
        .enable(tmo_ctrl_q[`HIRQ_TMO_EN]),
        .limit(tmo_ctrl_q[`HIRQ_TMO_VAL_HI:0]),
        .tmo_q(wr_tmo)
    );

    // Bus error flags: set only while enabled, cleared by writing zero
    // A time-out in the same cycle as the clear keeps its flag
    always @* begin
        be_set = 2'h0;
        be_set[`HIRQ_BE_RD] = rd_tmo && be_en_q[`HIRQ_BE_RD];
        be_set[`HIRQ_BE_WR] = wr_tmo && be_en_q[`HIRQ_BE_WR];
        be_clr = 2'h0;
        host_clr = 1'b0;
        if (do_write && (wr_idx == `HIRQ_IDX_BUS_ERR)) begin
            be_clr = wmask[1:0] & ~wval[1:0];
            host_clr = ((bus_err_q & ~be_clr) == 2'h0);
        end
    end

    hirq_sticky #(
        .W(2)
    ) u_bus_err (
        .core_clk(core_clk),
        .rst(rst),
        .set(be_set),
        .clr(be_clr),
        .flag_q(bus_err_q)
    );

    hirq_sticky #(
        .W(1)
    ) u_host_flag (
        .core_clk(core_clk),
        .rst(rst),
        .set((|be_set) || wait_tmo_evt),
        .clr(host_clr),
        .flag_q(host_flag_q)
    );

    // Own event status, cleared by writing ones to the clear register
    always @* begin
        evt_set = `HIRQ_EVT_RST;
        evt_set[`HIRQ_EVT_RD] = rd_tmo;
        evt_set[`HIRQ_EVT_WR] = wr_tmo;
        evt_set[`HIRQ_EVT_WAIT] = wait_tmo_evt;
        evt_clr = `HIRQ_EVT_RST;
        if (do_write && (wr_idx == `HIRQ_IDX_EVT_CLEAR) && w_strb_q[0]) begin
            evt_clr = w_data_q[`HIRQ_EVT_W-1:0];
        end
    end

    hirq_sticky #(
        .W(`HIRQ_EVT_W)
    ) u_evt (
        .core_clk(core_clk),
        .rst(rst),
        .set(evt_set),
        .clr(evt_clr),
        .flag_q(evt_q)
    );

    // AXI write address and data, taken in either order
    // Readys stay low until the response is taken: one write at a time
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= {AW{1'b0}};
            s_axi_awready <= 1'b1;
            w_hold_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HIRQ_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `HIRQ_RESP_OKAY : `HIRQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Writable control registers
    // Reserved bits of each word are dropped on write
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmo_ctrl_q <= `HIRQ_TMO_RST;
            be_en_q <= `HIRQ_BE_RST;
            pin_ctl_q <= `HIRQ_PIN_RST;
            evt_en_q <= `HIRQ_EVT_RST;
        end else if (do_write) begin
            if (wr_idx == `HIRQ_IDX_TMO_CTRL) begin
                if (w_strb_q[0]) begin
                    tmo_ctrl_q <= wval[7:0];
                end
            end else if (wr_idx == `HIRQ_IDX_BE_EN) begin
                if (w_strb_q[0]) begin
                    be_en_q <= wval[1:0];
                end
            end else if (wr_idx == `HIRQ_IDX_PIN_CTRL) begin
                if (w_strb_q[1]) begin
                    pin_ctl_q <= {wval[`HIRQ_PIN_EN], wval[`HIRQ_PIN_DRV], wval[`HIRQ_PIN_POL]};
                end
            end else if (wr_idx == `HIRQ_IDX_EVT_ENABLE) begin
                if (w_strb_q[0]) begin
                    evt_en_q <= w_data_q[`HIRQ_EVT_W-1:0];
                end
            end
        end
    end

    // Read mux; summary writes are ignored, reserved bits read zero
    always @* begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        if (rd_idx == `HIRQ_IDX_SUMMARY) begin
            rd_mux[15:0] = summary;
        end else if (rd_idx == `HIRQ_IDX_TMO_CTRL) begin
            rd_mux[7:0] = tmo_ctrl_q;
        end else if (rd_idx == `HIRQ_IDX_BUS_ERR) begin
            rd_mux[1:0] = bus_err_q;
        end else if (rd_idx == `HIRQ_IDX_BE_EN) begin
            rd_mux[1:0] = be_en_q;
        end else if (rd_idx == `HIRQ_IDX_PIN_CTRL) begin
            rd_mux[`HIRQ_PIN_EN] = pin_ctl_q[2];
            rd_mux[`HIRQ_PIN_DRV] = pin_ctl_q[1];
            rd_mux[`HIRQ_PIN_POL] = pin_ctl_q[0];
        end else if (rd_idx == `HIRQ_IDX_EVT_STATUS) begin
            rd_mux[`HIRQ_EVT_W-1:0] = evt_q;
        end else if (rd_idx == `HIRQ_IDX_EVT_CLEAR) begin
            rd_mux = 32'h00000000;
        end else if (rd_idx == `HIRQ_IDX_EVT_ENABLE) begin
            rd_mux[`HIRQ_EVT_W-1:0] = evt_en_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // AXI read channel, one cycle from address to data
    // Data registered from the live mux at the address handshake
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HIRQ_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `HIRQ_RESP_OKAY : `HIRQ_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Host request pin and level interrupt
    // Pin floats only for active low with drive off; pull-up makes idle high
    // Disabled pin shows no request rather than a frozen level
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_irq_pin_o <= 1'b0;
            host_irq_pin_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            host_irq_pin_o <= pin_ctl_q[0] ? req_active : !req_active;
            host_irq_pin_oe_n <= !pin_ctl_q[1] && !pin_ctl_q[0] && !req_active;
            irq <= |(evt_q & evt_en_q);
        end
    end
endmodule // hirq_top

// ==== inc/hirq_consts.vh ====
`ifndef HIRQ_CONSTS_VH
`define HIRQ_CONSTS_VH

// Register indices; byte address is four times the index
`define HIRQ_IDX_SUMMARY 8'h20
`define HIRQ_IDX_TMO_CTRL 8'h24
`define HIRQ_IDX_BUS_ERR 8'h26
`define HIRQ_IDX_BE_EN 8'h28
`define HIRQ_IDX_PIN_CTRL 8'h2A
`define HIRQ_IDX_EVT_STATUS 8'h30
`define HIRQ_IDX_EVT_CLEAR 8'h31
`define HIRQ_IDX_EVT_ENABLE 8'h32

// Interrupt summary fields
`define HIRQ_SUM_HOST 0
`define HIRQ_SUM_VSYNC 2
`define HIRQ_SUM_GPIO 3

// Host time-out control fields
`define HIRQ_TMO_EN 7
`define HIRQ_TMO_VAL_HI 6
`define HIRQ_TMO_RST 8'h7F
`define HIRQ_TMO_OFF 7'h00

// Bus error status and enable fields
`define HIRQ_BE_WR 0
`define HIRQ_BE_RD 1
`define HIRQ_BE_RST 2'h0

// Pin control fields
`define HIRQ_PIN_POL 11
`define HIRQ_PIN_DRV 13
`define HIRQ_PIN_EN 15
`define HIRQ_PIN_RST 3'h0

// Own event status layout
`define HIRQ_EVT_RD 0
`define HIRQ_EVT_WR 1
`define HIRQ_EVT_WAIT 2
`define HIRQ_EVT_W 3
`define HIRQ_EVT_RST 3'h0

// AXI responses
`define HIRQ_RESP_OKAY 2'h0
`define HIRQ_RESP_SLVERR 2'h2

`endif

// ==== hw/hirq_sticky.v ====
`timescale 1ns/1ns
// Sticky flags; a set in the same cycle as its clear wins
module hirq_sticky #(
    parameter W = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [W-1:0] set,
    input wire [W-1:0] clr,
    output reg [W-1:0] flag_q
);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_q <= {W{1'b0}};
        end else begin
            flag_q <= (flag_q & ~clr) | set;
        end
    end
endmodule // hirq_sticky

// ==== hw/hirq_timeout.v ====
`timescale 1ns/1ns
`include "hirq_consts.vh"
// Counts cycles of one host access, pulses once when it outlasts the limit
module hirq_timeout #(
    parameter W = 7
) (
    input wire core_clk,
    input wire rst,
    input wire busy,
    input wire enable,
    input wire [W-1:0] limit,
    output reg tmo_q
);
    reg [W:0] cnt_q;
    reg fired_q;
    wire hit;

    assign hit = busy && enable && (limit != {W{1'b0}}) && (cnt_q >= {1'b0, limit}) && !fired_q;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {(W+1){1'b0}};
            fired_q <= 1'b0;
            tmo_q <= 1'b0;
        end else begin
            tmo_q <= hit;
            if (!busy) begin
                cnt_q <= {(W+1){1'b0}};
                fired_q <= 1'b0;
            end else begin
                if (cnt_q != {(W+1){1'b1}}) begin
                    cnt_q <= cnt_q + {{W{1'b0}}, 1'b1};
                end
                if (hit) begin
                    fired_q <= 1'b1;
                end
            end
        end
    end
endmodule // hirq_timeout

// ==== test/hirq_chk_sva.sv ====
`timescale 1ns/1ns
`include "hirq_consts.vh"
module hirq_chk #(
    parameter AW = 8,
    parameter GPIO_W = 32
) (
    input wire core_clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [GPIO_W-1:0] port_gpio_status,
    input wire host_irq_pin_o,
    input wire host_irq_pin_oe_n
);
    reg [AW-1:0] ad_q;
    reg [15:0] wd_q;
    reg [2:0] pc_q;
    // Shadow of pin control: enable, drive, polarity
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ad_q <= 0;
            wd_q <= 0;
            pc_q <= 0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                ad_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd_q <= s_axi_wdata[15:0];
            if (s_axi_bvalid && s_axi_bready && ad_q == (`HIRQ_IDX_PIN_CTRL << 2) && s_axi_bresp == 2'h0)
                pc_q <= {wd_q[15], wd_q[13], wd_q[11]};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer missing");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer held");
    a_gpio_req: assert property (
        pc_q[2] && |port_gpio_status && !s_axi_bvalid |=> host_irq_pin_o == pc_q[0])
        else $error("pin not asserted on gpio");
    a_pin_off: assert property (
        !pc_q[2] && !s_axi_bvalid |=> host_irq_pin_o == !pc_q[0] && host_irq_pin_oe_n == !(pc_q[1] || pc_q[0]))
        else $error("disabled pin wrong");
    a_drive_on: assert property (pc_q[1] && !s_axi_bvalid |=> !host_irq_pin_oe_n)
        else $error("pin floats while drive set");
    a_float_high: assert property (!$past(rst) && host_irq_pin_oe_n |-> host_irq_pin_o)
        else $error("float while active");
endmodule // hirq_chk
bind hirq_top hirq_chk #(.AW(AW), .GPIO_W(GPIO_W)) u_chk (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .port_gpio_status, .host_irq_pin_o,
    .host_irq_pin_oe_n);

// ==== test/hirq_host_model.sv ====
`timescale 1ns/1ns
module hirq_host_model (
    input wire pin_o,
    input wire pin_oe_n,
    output wire pin_level
);
    // Pull-up holds the line high while undriven
    assign pin_level = pin_oe_n ? 1'b1 : pin_o;
endmodule // hirq_host_model

// ==== test/hirq_tb.sv ====
`timescale 1ns/1ns
`include "hirq_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module host_irq_and_bus_timeout_tb_top;
    reg core_clk = 0;
    reg rst = 1;
    reg [7:0] s_axi_awaddr = 0;
    reg s_axi_awvalid = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_wvalid = 0;
    reg s_axi_bready = 0;
    reg [7:0] s_axi_araddr = 0;
    reg s_axi_arvalid = 0;
    reg s_axi_rready = 0;
    reg [31:0] port_gpio_status = 0;
    reg vsync_status = 0;
    reg wait_tmo_evt = 0;
    reg host_rd_busy = 0;
    reg host_wr_busy = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire host_irq_pin_o, host_irq_pin_oe_n, irq, pin_level;
    integer fail_count = 0;
    integer compares = 0;
    integer cyc = 0;
    integer i;
    reg req;
    hirq_top dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_gpio_status, .vsync_status,
        .wait_tmo_evt, .host_rd_busy, .host_wr_busy, .host_irq_pin_o, .host_irq_pin_oe_n, .irq);
    hirq_host_model host (.pin_o(host_irq_pin_o), .pin_oe_n(host_irq_pin_oe_n), .pin_level);
    initial forever #50 core_clk = ~core_clk;
    task conclude;
        begin
            if (fail_count == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            conclude;
        end
    end
    task idle(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    task wr(input [7:0] idx, input [15:0] d, input [1:0] r);
        reg a, w;
        begin
            @(posedge core_clk);
            s_axi_awaddr <= {idx[5:0], 2'b00};
            s_axi_wdata <= {16'h0000, d};
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            a = 1;
            w = 1;
            while (a || w) begin
                @(posedge core_clk);
                if (a && s_axi_awready) begin
                    a = 0;
                    s_axi_awvalid <= 0;
                end
                if (w && s_axi_wready) begin
                    w = 0;
                    s_axi_wvalid <= 0;
                end
            end
            do @(posedge core_clk); while (!s_axi_bvalid);
            s_axi_bready <= 0;
            `CHK(s_axi_bresp, r)
        end
    endtask
    task rd(input [7:0] idx, input [15:0] e, input [1:0] r);
        begin
            @(posedge core_clk);
            s_axi_araddr <= {idx[5:0], 2'b00};
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do @(posedge core_clk); while (!s_axi_arready);
            s_axi_arvalid <= 0;
            do @(posedge core_clk); while (!s_axi_rvalid);
            s_axi_rready <= 0;
            `CHK(s_axi_rdata, {16'h0000, e})
            `CHK(s_axi_rresp, r)
        end
    endtask
    task busy(input [1:0] which, input integer n);
        begin
            @(posedge core_clk);
            {host_rd_busy, host_wr_busy} <= which;
            idle(n);
            {host_rd_busy, host_wr_busy} <= 2'b00;
            idle(4);
        end
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 0;
        rd(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        rd(`HIRQ_IDX_TMO_CTRL, 16'h007F, 0);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        rd(`HIRQ_IDX_BE_EN, 16'h0000, 0);
        rd(`HIRQ_IDX_PIN_CTRL, 16'h0000, 0);
        rd(8'h10, 16'h0000, `HIRQ_RESP_SLVERR);
        rd(8'h1C, 16'h0000, `HIRQ_RESP_SLVERR);
        wr(8'h10, 16'h0000, `HIRQ_RESP_SLVERR);
        port_gpio_status <= 32'h80000000;
        rd(`HIRQ_IDX_SUMMARY, 16'h0008, 0);
        port_gpio_status <= 0;
        vsync_status <= 1;
        rd(`HIRQ_IDX_SUMMARY, 16'h0004, 0);
        vsync_status <= 0;
        wr(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        rd(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        for (i = 0; i < 16; i++) begin
            port_gpio_status <= {31'h0, i[3]};
            wr(`HIRQ_IDX_PIN_CTRL, {i[2], 1'b0, i[1], 1'b0, i[0], 11'h000}, 0);
            idle(2);
            req = i[2] & i[3];
            `CHK(pin_level, i[0] ? req : !req)
            `CHK(host_irq_pin_oe_n, !i[1] & !i[0] & !req)
        end
        rd(`HIRQ_IDX_PIN_CTRL, 16'hA800, 0);
        port_gpio_status <= 0;
        wr(`HIRQ_IDX_BE_EN, 16'h0003, 0);
        rd(`HIRQ_IDX_BE_EN, 16'h0003, 0);
        wr(`HIRQ_IDX_TMO_CTRL, 16'h0080, 0);
        busy(2'b10, 20);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        wr(`HIRQ_IDX_TMO_CTRL, 16'h0005, 0);
        busy(2'b10, 20);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        wr(`HIRQ_IDX_TMO_CTRL, 16'h0085, 0);
        busy(2'b10, 5);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        busy(2'b10, 6);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0002, 0);
        rd(`HIRQ_IDX_SUMMARY, 16'h0001, 0);
        wr(`HIRQ_IDX_BE_EN, 16'h0001, 0);
        wr(`HIRQ_IDX_BUS_ERR, 16'h0001, 0);
        rd(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        busy(2'b10, 6);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        busy(2'b01, 6);
        rd(`HIRQ_IDX_BUS_ERR, 16'h0001, 0);
        wr(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        rd(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        wait_tmo_evt <= 1;
        idle(1);
        wait_tmo_evt <= 0;
        rd(`HIRQ_IDX_SUMMARY, 16'h0001, 0);
        wr(`HIRQ_IDX_BUS_ERR, 16'h0000, 0);
        rd(`HIRQ_IDX_SUMMARY, 16'h0000, 0);
        rd(`HIRQ_IDX_EVT_STATUS, 16'h0007, 0);
        `CHK(irq, 1'b0)
        wr(`HIRQ_IDX_EVT_ENABLE, 16'h0002, 0);
        idle(2);
        `CHK(irq, 1'b1)
        wr(`HIRQ_IDX_EVT_CLEAR, 16'h0002, 0);
        idle(2);
        `CHK(irq, 1'b0)
        rd(`HIRQ_IDX_EVT_STATUS, 16'h0005, 0);
        conclude;
    end
endmodule // host_irq_and_bus_timeout_tb_top
